// ### ledbpo_host_model.sv
// Host model driving the register port in place of the serial bus controller
`timescale 1ns/100ps
module ledbpo_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr
);
  // Idle bus from time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
  end

  // One-cycle strobe, address and data held across the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;  // Stale data never looks valid
  endtask : wr

  // Present address, let registered data land, then take it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : ledbpo_host_model

// ### ledbpo_pkg.sv
// Shared addresses, field positions, reset values and timing for the LED blink/phase block
package ledbpo_pkg;
  // Register address codes
  localparam logic [7:0] ADDR_PHASE_ZERO = 8'h01;
  localparam logic [7:0] ADDR_PHASE_ONE  = 8'h09;
  localparam logic [7:0] ADDR_MASTER     = 8'h0E;
  localparam logic [7:0] ADDR_CONFIG     = 8'h0F;
  localparam logic [7:0] ADDR_INTENS_0   = 8'h10;
  localparam logic [7:0] ADDR_INTENS_1   = 8'h11;
  localparam logic [7:0] ADDR_INTENS_2   = 8'h12;
  localparam logic [7:0] ADDR_INTENS_3   = 8'h13;

  // Configuration register field positions
  localparam int CFG_BLINK_EN   = 0;
  localparam int CFG_BLINK_FLIP = 1;
  localparam int CFG_GLOBAL     = 2;
  localparam int CFG_NINTH_P0   = 4;
  localparam int CFG_NINTH_P1   = 5;
  localparam int CFG_PIN_STATUS = 6;

  // Writable configuration bits (D7, D6, D3 are not stored)
  localparam logic [7:0] CFG_WR_MASK = 8'h37;

  // Power-up register contents
  localparam logic [7:0] RST_PHASE  = 8'hFF;
  localparam logic [7:0] RST_MASTER = 8'h0F;
  localparam logic [7:0] RST_CONFIG = 8'h34;
  localparam logic [7:0] RST_INTENS = 8'hFF;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // PWM timing: 15 master timeslots of 16 cycles each
  localparam logic [3:0] PWM_LAST_CYCLE = 4'hF;
  localparam logic [3:0] PWM_LAST_SLOT  = 4'hE;
  localparam logic [3:0] NIBBLE_STATIC  = 4'hF;
  localparam logic [3:0] NIBBLE_ZERO    = 4'h0;
  localparam int         NUM_OUTS       = 8;
endpackage : ledbpo_pkg

// ### ledbpo_pwm_timer.sv
// PWM timeslot generator: cycle within slot and master timeslot index
`timescale 1ns/100ps
module ledbpo_pwm_timer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  output logic      [3:0] cycle,
  output logic      [3:0] slot
);
  logic       cycle_wrap;
  logic       slot_wrap;
  logic [3:0] next_cycle;
  logic [3:0] next_slot;

  // Counter stepping; held at zero while PWM is off
  assign cycle_wrap = (cycle == ledbpo_pkg::PWM_LAST_CYCLE);
  assign slot_wrap  = (slot == ledbpo_pkg::PWM_LAST_SLOT);
  assign next_cycle = !run ? 4'h0 : (cycle + 4'h1);
  assign next_slot  = !run ? 4'h0 :
                      (cycle_wrap ? (slot_wrap ? 4'h0 : slot + 4'h1) : slot);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle <= 4'h0;
      slot  <= 4'h0;
    end else begin
      cycle <= next_cycle;
      slot  <= next_slot;
    end
  end
endmodule : ledbpo_pwm_timer

// ### ledbpo_sync2.sv
// Two-stage synchroniser for an asynchronous level input
`timescale 1ns/100ps
module ledbpo_sync2 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage_one;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= 1'b0;
      sync_out  <= 1'b0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule : ledbpo_sync2

// ### ledbpo_top.sv
// Blink phase selection, intensity mode decode and open-drain output control
// Operation
// - Config 0x0F holds enable, flip, global, ninth-output phase levels; D7, D3 ignored
// - Blink off: ninth output sinks low when config D4 is 0
// - Blink on, phase 0: ninth output follows D4, 0 low, 1 high-Z
// - Blink on, phase 1: ninth output follows D5, 0 low, 1 high-Z
// - Reading config D6 returns the blink input pin level
// - Active phase is flip XOR pin when enabled, else phase 0
// - Phase-0 register 0x01, bit n drives output n, read/write
// - Phase-1 register 0x09, bit n drives output n, read/write
// - Master 0x00..0x0F: all outputs static, global and individual ignored
// - Master 0x10..0xFF enables PWM operation
// - Individual intensity 0xF static, 0x0..0xE PWM, with global cleared
// - Global set: only 0x0E sets intensity, 0x10..0x13 ignored
// - Global on: low nibble of 0x0E sets every output's intensity
// - Blink off: phase-0 bit sets level during PWM on-time
// - Intensity 16/16 ignores master gating, follows active phase bit
`timescale 1ns/100ps
module ledbpo_top (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       blink_pin,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  output logic      [7:0] reg_rdata,
  output logic      [8:0] out_level,
  output logic      [8:0] out_oe
);
  logic        rst_meta;
  logic        rst_sync_n;
  logic        pin_sync;
  logic [7:0]  output_level_phase_zero;
  logic [7:0]  output_level_phase_one;
  logic [7:0]  master_intensity;
  logic [7:0]  device_configuration;
  logic [31:0] output_intensity;
  logic [3:0]  pwm_cycle;
  logic [3:0]  pwm_slot;
  logic        blink_en;
  logic        blink_flip;
  logic        global_sel;
  logic        phase_one;
  logic        pwm_run;
  logic [7:0]  active_bits;
  logic        ninth_bit;
  logic [3:0]  ninth_intensity;
  logic [7:0]  cfg_readback;
  logic [7:0]  next_rdata;
  logic [8:0]  next_level;

  // Level that the pin shows: static or gated by the PWM on-time
  function automatic logic pin_level(input logic bit_val, input logic run,
                                     input logic [3:0] master_hi, input logic [3:0] intens,
                                     input logic [3:0] slot, input logic [3:0] cyc);
    logic on_time;
    on_time = (slot < master_hi) && (cyc <= intens);
    if (!run || intens == ledbpo_pkg::NIBBLE_STATIC) begin
      pin_level = bit_val;
    end else begin
      pin_level = on_time ? bit_val : ~bit_val;
    end
  endfunction : pin_level

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Blink pin synchroniser
  ledbpo_sync2 u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_sync_n),
    .async_in (blink_pin),
    .sync_out (pin_sync)
  );

  // PWM timeslot counters, running only while PWM is on
  ledbpo_pwm_timer u_pwm (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .run   (pwm_run),
    .cycle (pwm_cycle),
    .slot  (pwm_slot)
  );

  // Register writes
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      output_level_phase_zero <= ledbpo_pkg::RST_PHASE;
      output_level_phase_one  <= ledbpo_pkg::RST_PHASE;
      master_intensity        <= ledbpo_pkg::RST_MASTER;
      device_configuration    <= ledbpo_pkg::RST_CONFIG;
      output_intensity        <= {4{ledbpo_pkg::RST_INTENS}};
    end else if (reg_wr) begin
      case (reg_addr)
        ledbpo_pkg::ADDR_PHASE_ZERO: output_level_phase_zero <= reg_wdata;
        ledbpo_pkg::ADDR_PHASE_ONE:  output_level_phase_one  <= reg_wdata;
        ledbpo_pkg::ADDR_MASTER:     master_intensity        <= reg_wdata;
        ledbpo_pkg::ADDR_CONFIG:
          device_configuration <= reg_wdata & ledbpo_pkg::CFG_WR_MASK;
        ledbpo_pkg::ADDR_INTENS_0:   output_intensity[7:0]   <= reg_wdata;
        ledbpo_pkg::ADDR_INTENS_1:   output_intensity[15:8]  <= reg_wdata;
        ledbpo_pkg::ADDR_INTENS_2:   output_intensity[23:16] <= reg_wdata;
        ledbpo_pkg::ADDR_INTENS_3:   output_intensity[31:24] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Configuration fields and phase selection
  assign blink_en   = device_configuration[ledbpo_pkg::CFG_BLINK_EN];
  assign blink_flip = device_configuration[ledbpo_pkg::CFG_BLINK_FLIP];
  assign global_sel = device_configuration[ledbpo_pkg::CFG_GLOBAL];
  assign phase_one  = blink_en & (blink_flip ^ pin_sync);
  assign active_bits = phase_one ? output_level_phase_one
                                 : output_level_phase_zero;
  assign ninth_bit  = phase_one ? device_configuration[ledbpo_pkg::CFG_NINTH_P1]
                                : device_configuration[ledbpo_pkg::CFG_NINTH_P0];

  // PWM runs only when master upper nibble is non-zero
  assign pwm_run         = (master_intensity[7:4] != ledbpo_pkg::NIBBLE_ZERO);
  assign ninth_intensity = master_intensity[3:0];

  // Next pin levels; global select swaps in the master low nibble
  always_comb begin
    for (int i = 0; i < ledbpo_pkg::NUM_OUTS; i++) begin
      next_level[i] = pin_level(active_bits[i], pwm_run, master_intensity[7:4],
                                global_sel ? master_intensity[3:0]
                                           : output_intensity[4*i +: 4],
                                pwm_slot, pwm_cycle);
    end
    next_level[8] = pin_level(ninth_bit, pwm_run, master_intensity[7:4],
                              ninth_intensity, pwm_slot, pwm_cycle);
  end

  // Read-back data; D6 carries the pin, D7 and D3 read zero
  assign cfg_readback = {1'b0, pin_sync,
                         device_configuration[ledbpo_pkg::CFG_NINTH_P1:ledbpo_pkg::CFG_BLINK_EN]};
  assign next_rdata =
    (reg_addr == ledbpo_pkg::ADDR_PHASE_ZERO) ? output_level_phase_zero :
    (reg_addr == ledbpo_pkg::ADDR_PHASE_ONE)  ? output_level_phase_one  :
    (reg_addr == ledbpo_pkg::ADDR_MASTER)     ? master_intensity        :
    (reg_addr == ledbpo_pkg::ADDR_CONFIG)     ? cfg_readback            :
    (reg_addr == ledbpo_pkg::ADDR_INTENS_0)   ? output_intensity[7:0]   :
    (reg_addr == ledbpo_pkg::ADDR_INTENS_1)   ? output_intensity[15:8]  :
    (reg_addr == ledbpo_pkg::ADDR_INTENS_2)   ? output_intensity[23:16] :
    (reg_addr == ledbpo_pkg::ADDR_INTENS_3)   ? output_intensity[31:24] :
    ledbpo_pkg::RD_UNMAPPED;

  // Registered outputs: open drain sinks when level is 0
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= ledbpo_pkg::RD_UNMAPPED;
      out_level <= 9'h000;
      out_oe    <= 9'h000;
    end else begin
      reg_rdata <= next_rdata;
      out_level <= 9'h000;
      out_oe    <= ~next_level;
    end
  end

  // Assertions
  a_cfg_write_mask: assert property (@(posedge clk) disable iff (!rst_sync_n)
    reg_wr && reg_addr == ledbpo_pkg::ADDR_CONFIG |=>
      device_configuration == ($past(reg_wdata) & ledbpo_pkg::CFG_WR_MASK))
    else $error("config write stored unmasked bits");

  a_ninth_blink_off: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !blink_en && !pwm_run |=>
      out_oe[8] == !$past(device_configuration[ledbpo_pkg::CFG_NINTH_P0]))
    else $error("ninth output wrong with blink off");

  a_ninth_phase_zero: assert property (@(posedge clk) disable iff (!rst_sync_n)
    blink_en && !(blink_flip ^ pin_sync) && !pwm_run |=>
      out_oe[8] == !$past(device_configuration[ledbpo_pkg::CFG_NINTH_P0]))
    else $error("ninth output wrong in phase 0");

  a_ninth_phase_one: assert property (@(posedge clk) disable iff (!rst_sync_n)
    blink_en && (blink_flip ^ pin_sync) && !pwm_run |=>
      out_oe[8] == !$past(device_configuration[ledbpo_pkg::CFG_NINTH_P1]))
    else $error("ninth output wrong in phase 1");

  a_pin_readback: assert property (@(posedge clk) disable iff (!rst_sync_n)
    reg_addr == ledbpo_pkg::ADDR_CONFIG |=> reg_rdata[6] == $past(pin_sync) && !reg_rdata[7]
      && !reg_rdata[3])
    else $error("config readback wrong");

  a_phase_select: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !pwm_run |=> out_oe[7:0] == ~$past((blink_en && (blink_flip != pin_sync))
      ? output_level_phase_one : output_level_phase_zero))
    else $error("blink phase selection wrong");

  a_phase0_rw: assert property (@(posedge clk) disable iff (!rst_sync_n)
    reg_wr && reg_addr == ledbpo_pkg::ADDR_PHASE_ZERO ##1 reg_addr == ledbpo_pkg::ADDR_PHASE_ZERO
      && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
    else $error("phase 0 register read-back wrong");

  a_phase1_rw: assert property (@(posedge clk) disable iff (!rst_sync_n)
    reg_wr && reg_addr == ledbpo_pkg::ADDR_PHASE_ONE ##1 reg_addr == ledbpo_pkg::ADDR_PHASE_ONE
      && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
    else $error("phase 1 register read-back wrong");

  a_static_master: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !pwm_run |=> out_oe[7:0] == ~$past(active_bits))
    else $error("static outputs do not follow active phase");

  a_pwm_counting: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pwm_run && pwm_cycle != ledbpo_pkg::PWM_LAST_CYCLE |=>
      pwm_cycle == $past(pwm_cycle) + 4'h1)
    else $error("PWM timer not running");

  a_full_intensity: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !global_sel && output_intensity[3:0] == ledbpo_pkg::NIBBLE_STATIC |=>
      out_oe[0] == !$past(active_bits[0]))
    else $error("16/16 output not static");

  a_global_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
    global_sel && pwm_run && master_intensity[3:0] != ledbpo_pkg::NIBBLE_STATIC
      && pwm_slot >= master_intensity[7:4] |=>
      out_oe[7:0] == $past(active_bits))
    else $error("global gating wrong outside enabled slots");

  a_open_drain: assert property (@(posedge clk) disable iff (!rst_sync_n)
    out_level == 9'h000)
    else $error("open-drain output driven high");

  // Intensity mode checks on the individual and global paths
  a_full_intensity_one: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !global_sel && output_intensity[7:4] == ledbpo_pkg::NIBBLE_STATIC |=>
      out_oe[1] == !$past(active_bits[1]))
    else $error("16/16 output 1 not static");

  a_individual_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !global_sel && pwm_run && output_intensity[3:0] != ledbpo_pkg::NIBBLE_STATIC
      && pwm_slot >= master_intensity[7:4] |=> out_oe[0] == $past(active_bits[0]))
    else $error("individual gating wrong outside enabled slots");

  a_global_on_time: assert property (@(posedge clk) disable iff (!rst_sync_n)
    global_sel && pwm_run && master_intensity[3:0] != ledbpo_pkg::NIBBLE_STATIC
      && pwm_slot < master_intensity[7:4] && pwm_cycle <= master_intensity[3:0] |=>
      out_oe[7:0] == ~$past(active_bits))
    else $error("global on-time level wrong");

  a_global_static: assert property (@(posedge clk) disable iff (!rst_sync_n)
    global_sel && master_intensity[3:0] == ledbpo_pkg::NIBBLE_STATIC |=>
      out_oe[7:0] == ~$past(active_bits))
    else $error("global 16/16 outputs not static");

  // Ninth output under PWM
  a_ninth_on_time: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pwm_run && master_intensity[3:0] != ledbpo_pkg::NIBBLE_STATIC
      && pwm_slot < master_intensity[7:4] && pwm_cycle <= master_intensity[3:0] |=>
      out_oe[8] == !$past(ninth_bit))
    else $error("ninth output on-time level wrong");

  a_ninth_off_time: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pwm_run && master_intensity[3:0] != ledbpo_pkg::NIBBLE_STATIC
      && pwm_slot >= master_intensity[7:4] |=> out_oe[8] == $past(ninth_bit))
    else $error("ninth output off-time level wrong");

  a_ninth_static_pwm: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pwm_run && master_intensity[3:0] == ledbpo_pkg::NIBBLE_STATIC |=>
      out_oe[8] == !$past(ninth_bit))
    else $error("ninth output 16/16 not static");

  // Timeslot counter behaviour
  a_timer_idle: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !pwm_run |=> pwm_cycle == ledbpo_pkg::NIBBLE_ZERO && pwm_slot == ledbpo_pkg::NIBBLE_ZERO)
    else $error("PWM timer not held while static");

  a_slot_wrap: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pwm_run && pwm_cycle == ledbpo_pkg::PWM_LAST_CYCLE && pwm_slot == ledbpo_pkg::PWM_LAST_SLOT
      |=> pwm_slot == ledbpo_pkg::NIBBLE_ZERO)
    else $error("master timeslot did not wrap");

  a_slot_range: assert property (@(posedge clk) disable iff (!rst_sync_n)
    pwm_slot <= ledbpo_pkg::PWM_LAST_SLOT)
    else $error("master timeslot out of range");

  // Read-back of intensity registers
  a_master_rw: assert property (@(posedge clk) disable iff (!rst_sync_n)
    reg_wr && reg_addr == ledbpo_pkg::ADDR_MASTER ##1 reg_addr == ledbpo_pkg::ADDR_MASTER
      && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
    else $error("master register read-back wrong");

  a_intens_rw: assert property (@(posedge clk) disable iff (!rst_sync_n)
    reg_wr && reg_addr == ledbpo_pkg::ADDR_INTENS_1 ##1 reg_addr == ledbpo_pkg::ADDR_INTENS_1
      && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
    else $error("intensity register read-back wrong");
endmodule : ledbpo_top

// ### tb.sv
// Self-checking bench for the LED blink phase and intensity block
`timescale 1ns/100ps
module tb;
  logic       clk;
  logic       rst_n;
  logic       blink_pin;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic [7:0] reg_rdata;
  logic [8:0] out_level;
  logic [8:0] out_oe;
  logic [8:0] exp_q[$];
  logic [8:0] obs;
  logic [8:0] ev;
  event       obs_ev;
  int         error_cnt;
  int         checks;
  logic [7:0] p0;
  logic [7:0] p1;
  logic [7:0] v;
  logic [7:0] cfg;
  logic [2:0] k;
  logic       ph;

  ledbpo_top uut (.clk(clk), .rst_n(rst_n), .blink_pin(blink_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .out_level(out_level),
    .out_oe(out_oe));
  ledbpo_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Takes the oldest note whenever a result appears
  always @(obs_ev) begin
    checks++;
    ev = exp_q.pop_front();
    if (ev !== obs) begin
      error_cnt++;
      $display("Error t=%0t exp=%h got=%h", $time, ev, obs);
    end
  end

  task automatic note(input logic [8:0] e, input logic [8:0] o);
    exp_q.push_back(e);
    obs = o;
    ->obs_ev;
    #1;
  endtask : note

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    note({1'b0, e}, {1'b0, d});
  endtask : rd_chk

  // Count cycles of one PWM period with the output sinking
  task automatic cnt_chk(input int idx, input logic [8:0] e);
    int n;
    n = 0;
    repeat (4) @(posedge clk);
    repeat (240) begin
      @(posedge clk);
      if (out_oe[idx] === 1'b1) n++;
    end
    note(e, 9'(n));
  endtask : cnt_chk

  task automatic complete_run;
    error_cnt += exp_q.size();
    $display("Counts checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // Hang guard
  initial begin
    #(25 * 60000);
    error_cnt++;
    $display("Error t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
    complete_run();
  end

  // Main sequence
  initial begin
    error_cnt = 0;
    checks = 0;
    rst_n = 1'b0;
    blink_pin = 1'b0;
    void'($urandom(32'h1de2));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(8'h01, 8'hFF);
    rd_chk(8'h09, 8'hFF);
    rd_chk(8'h0E, 8'h0F);
    rd_chk(8'h0F, 8'h34);
    rd_chk(8'h03, 8'h00);
    $display("Test reset_values done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom());
      host.wr(8'h0F, v);
      rd_chk(8'h0F, v & 8'h37);
      host.wr(8'h01, v);
      rd_chk(8'h01, v);
      host.wr(8'h09, ~v);
      rd_chk(8'h09, ~v);
      host.wr(8'h0E, {4'h0, v[3:0]});
      rd_chk(8'h0E, {4'h0, v[3:0]});
      host.wr(8'h11, v);
      rd_chk(8'h11, v);
    end
    $display("Test register_access done");
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      p0 = 8'($urandom());
      p1 = 8'($urandom());
      v = 8'($urandom());
      cfg = {2'b00, v[1:0], 2'b00, k[1:0]};
      host.wr(8'h01, p0);
      host.wr(8'h09, p1);
      host.wr(8'h0F, cfg);
      blink_pin <= k[2];
      ph = k[0] & (k[1] ^ k[2]);
      repeat (5) @(posedge clk);
      note(ph ? {~cfg[5], ~p1} : {~cfg[4], ~p0}, out_oe);
      note(9'h000, out_level);
      rd_chk(8'h0F, cfg | {1'b0, k[2], 6'b0});
    end
    $display("Test blink_phase done");
    blink_pin <= 1'b0;
    host.wr(8'h0F, 8'h00);
    host.wr(8'h01, 8'h00);
    host.wr(8'h10, 8'hF3);
    host.wr(8'h0E, 8'h50);
    cnt_chk(0, 9'd20);
    cnt_chk(1, 9'd240);
    cnt_chk(8, 9'd5);
    host.wr(8'h0F, 8'h04);
    host.wr(8'h0E, 8'h52);
    cnt_chk(0, 9'd15);
    cnt_chk(1, 9'd15);
    host.wr(8'h0E, 8'h5F);
    cnt_chk(0, 9'd240);
    cnt_chk(8, 9'd240);
    host.wr(8'h0E, 8'h0F);
    cnt_chk(0, 9'd240);
    $display("Test intensity_modes done");
    #1;
    complete_run();
  end
endmodule : tb
